// ===== dv/direct_space_indirect_gpio_rxcell_tb.sv
`timescale 1ns/100ps
module direct_space_indirect_gpio_rxcell_tb;
  logic clock, rst_n, up_wr, up_rd, big_end, rx_wr, up_rvalid;
  logic ext_req, ext_ack;
  logic [7:0] up_addr, up_wdata, up_rdata, rx_byte, gpio_o, gpio_oe, pins;
  logic [7:0] rv;
  logic [1:0] ext_we;
  logic [25:1] ext_waddr;
  logic [15:0] ext_wdata, ext_rdata;
  logic [5:0] rx_idx;
  logic [3:0] lat;
  int errors, comparisons;
  // {addr, write, expected read}
  logic [23:0] rows [11] = '{24'h30FF01, 24'h315A5A, 24'h32C3C3, 24'h33FFE0,
    24'h341F1F, 24'h36ABAB, 24'h37CDCD, 24'h390F0F, 24'h3BA5A5, 24'h385500,
    24'h947700};
  // {control, data high, data low, expected high, expected low}
  logic [39:0] ops [3] = '{40'hFF12341234, 40'hBFEE771277, 40'hDF99559977};
  // pin level from both drivers
  wire [7:0] gpio_i = (gpio_oe & gpio_o) | (~gpio_oe & pins);
  dsg_top dut (.clock, .rst_n, .up_addr, .up_wdata, .up_wr, .up_rd,
    .up_rdata, .up_rvalid, .big_end, .ext_req, .ext_we, .ext_waddr,
    .ext_wdata, .ext_rdata, .ext_ack, .rx_wr, .rx_idx, .rx_byte, .gpio_i,
    .gpio_o, .gpio_oe);
  dsg_mem_model mem (.clock, .rst_n, .ext_req, .ext_we, .ext_waddr,
    .ext_wdata, .lat, .ext_rdata, .ext_ack);
  //////////////////////////////
  // clock
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    up_addr = a;
    up_wdata = d;
    up_wr = 1'b1;
    @(negedge clock);
    up_wr = 1'b0;
  endtask : wr
  task rd(input logic [7:0] a);
    @(negedge clock);
    up_addr = a;
    up_rd = 1'b1;
    @(negedge clock);
    chk("read valid", 1, up_rvalid);
    rv = up_rdata;
    up_rd = 1'b0;
  endtask : rd
  task rc(input logic [7:0] a, input logic [7:0] exp);
    rd(a);
    chk($sformatf("reg %h", a), exp, rv);
  endtask : rc
  task wait_idle;
    for (int n = 0; n < 40 && rv[7] !== 1'b0; n++) rd(8'h34);
    chk("go bit", 0, rv[7]);
  endtask : wait_idle
  task tally_and_finish;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish
  //////////////////////////////
  // watchdog
  initial begin
    #50000;
    errors++;
    tally_and_finish();
  end
  // main sequence
  initial begin
    {rst_n, up_wr, up_rd, rx_wr, up_addr, up_wdata, rx_idx, rx_byte} = '0;
    {pins, lat, errors, comparisons} = '0;
    big_end = 1'b1;
    repeat (12) @(negedge clock);
    rst_n = 1'b1;
    foreach (rows[i]) rc(rows[i][23:16], 8'h00);
    $display("test reset done");
    foreach (rows[i]) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rc(rows[i][23:16], rows[i][7:0]);
    end
    $display("test rows done");
    chk("pin enable", 8'h0F, gpio_oe);
    chk("pin drive", 8'h05, gpio_o);
    pins = 8'h3C;
    repeat (6) @(negedge clock);
    rc(8'h3D, 8'h35);
    $display("test pins done");
    foreach (ops[i]) begin
      lat = 4'(i * 3);
      wr(8'h36, ops[i][31:24]);
      wr(8'h37, ops[i][23:16]);
      wr(8'h34, ops[i][39:32]);
      chk("word addr", 25'h15AC3FF, ext_waddr);
      rv = 8'h80;
      wait_idle();
      wr(8'h34, 8'h9F);
      rv = 8'h80;
      wait_idle();
      rc(8'h36, ops[i][15:8]);
      rc(8'h37, ops[i][7:0]);
    end
    $display("test indirect done");
    big_end = 1'b0;
    rc(8'h36, 8'h77);
    rc(8'h37, 8'h99);
    rc(8'h33, 8'h01);
    rc(8'h30, 8'hE0);
    $display("test order done");
    for (int i = 0; i < 53; i++) begin
      @(negedge clock);
      {rx_wr, rx_idx, rx_byte} = {1'b1, 6'(i), 8'(i) ^ 8'hA5};
    end
    @(negedge clock);
    rx_wr = 1'b0;
    for (int i = 0; i < 52; i++) rc(8'(8'h60 + i), 8'(i) ^ 8'hA5);
    rc(8'h94, 8'h00);
    $display("test cell done");
    // an address write while an access runs must be refused
    big_end = 1'b1;
    lat = 4'hF;
    wr(8'h34, 8'h9F);
    wr(8'h31, 8'h00);
    rc(8'h31, 8'h5A);
    rv = 8'h80;
    wait_idle();
    chk("word addr", 25'h15AC3FF, ext_waddr);
    $display("test busy done");
    // writes in little-endian order read back in big-endian order
    big_end = 1'b0;
    wr(8'h30, 8'h40);
    wr(8'h37, 8'h3C);
    big_end = 1'b1;
    rc(8'h33, 8'h40);
    rc(8'h36, 8'h3C);
    $display("test little write done");
    rst_n = 1'b0;
    repeat (2) @(negedge clock);
    rst_n = 1'b1;
    rc(8'h39, 8'h00);
    chk("pin enable", 8'h00, gpio_oe);
    $display("test rereset done");
    tally_and_finish();
  end
endmodule : direct_space_indirect_gpio_rxcell_tb

// ===== dv/dsg_mem_model.sv
`timescale 1ns/100ps
module dsg_mem_model (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // request side
  input wire logic ext_req,
  input wire logic [1:0] ext_we,
  input wire logic [25:1] ext_waddr,
  input wire logic [15:0] ext_wdata,
  input wire logic [3:0] lat,
  // answer side
  output logic [15:0] ext_rdata,
  output logic ext_ack
);
  logic [15:0] mem [logic [25:1]];
  logic [15:0] word;
  int cnt;
  // answers after lat idle cycles; data toggles when not valid
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ext_ack <= 1'b0;
      cnt <= 0;
      ext_rdata <= 16'h0000;
    end else if (ext_req && !ext_ack && cnt >= lat) begin
      ext_ack <= 1'b1;
      cnt <= 0;
      word = mem.exists(ext_waddr) ? mem[ext_waddr] : 16'h0000;
      if (ext_we[1]) word[15:8] = ext_wdata[15:8];
      if (ext_we[0]) word[7:0] = ext_wdata[7:0];
      mem[ext_waddr] = word;
      ext_rdata <= (ext_we == 2'b00) ? word : ~ext_rdata;
    end else begin
      ext_ack <= 1'b0;
      cnt <= (ext_req && !ext_ack) ? cnt + 1 : 0;
      ext_rdata <= ~ext_rdata;
    end
  end
endmodule : dsg_mem_model

// ===== dv/dsg_top_asserts.sv
`timescale 1ns/100ps
module dsg_top_asserts (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] up_addr,
  input wire logic [7:0] up_wdata,
  input wire logic up_wr,
  input wire logic up_rd,
  input wire logic [7:0] up_rdata,
  input wire logic up_rvalid,
  input wire logic big_end,
  // memory port
  input wire logic ext_req,
  input wire logic [1:0] ext_we,
  input wire logic [25:1] ext_waddr,
  input wire logic ext_ack,
  // pins
  input wire logic [7:0] gpio_o,
  input wire logic [7:0] gpio_oe
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // strobe decodes
  wire go_wr = up_wr && up_addr == 8'h34 && up_wdata[7];
  wire dir_wr = up_wr && up_addr == 8'h39;
  //////////////////////////////
  a_launch_fields: assert property (go_wr && !ext_req |=> ext_req &&
    ext_we == $past(up_wdata[6:5]) && ext_waddr[5:1] == $past(up_wdata[4:0]))
    else $error("launch fields wrong");
  a_go_clears: assert property (ext_req && ext_ack |=> !ext_req)
    else $error("request stayed after ack");
  a_req_waits: assert property ($fell(ext_req) |-> $past(ext_ack))
    else $error("request dropped without ack");
  a_fields_stable: assert property (ext_req && !ext_ack |=>
    $stable(ext_we) && $stable(ext_waddr)) else $error("fields moved");
  a_rvalid_follows: assert property (1'b1 |=> up_rvalid == $past(up_rd))
    else $error("read valid misplaced");
  a_reserved_zero: assert property (up_rd && up_addr == 8'h33 &&
    big_end |=> up_rdata[4:0] == 5'h00) else $error("reserved bits set");
  a_drive_masked: assert property ((gpio_o & ~gpio_oe) == 8'h00)
    else $error("pin driven while input");
  a_dir_applies: assert property (dir_wr ##1 !dir_wr [*2] |=>
    gpio_oe == $past(up_wdata, 3)) else $error("direction not applied");
  a_unmapped_zero: assert property (up_rd && up_addr == 8'h38 |=>
    up_rdata == 8'h00) else $error("unmapped read not zero");
  // main scenarios
  c_read_launch: cover property (go_wr && up_wdata[6:5] == 2'b00);
  c_word_write: cover property (ext_req && ext_ack && ext_we == 2'b11);
  c_dir_write: cover property (dir_wr);
endmodule : dsg_top_asserts
bind dsg_top dsg_top_asserts u_chk (.clock, .rst_n, .up_addr, .up_wdata,
  .up_wr, .up_rd, .up_rdata, .up_rvalid, .big_end, .ext_req, .ext_we,
  .ext_waddr, .ext_ack, .gpio_o, .gpio_oe);

// ===== hdl/dsg_gpio.sv
`timescale 1ns/100ps
module dsg_gpio (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // register side
  dsg_gpio_if.pins bus,
  // pins
  input wire logic [7:0] gpio_i,
  output logic [7:0] gpio_o,
  output logic [7:0] gpio_oe
);
  logic [7:0] s1_q;
  logic [7:0] s2_q;
  logic [7:0] s3_q;
  logic [7:0] level_q;
  logic [7:0] out_q;
  logic [7:0] oe_q;
  logic [7:0] agree;

  ////////////////////////////////////////////////////////////////////////
  // a bit counts once stages two and three agree
  assign agree = ~(s2_q ^ s3_q);
  assign bus.sampled = level_q;
  assign gpio_o = out_q;
  assign gpio_oe = oe_q;

  // pin synchroniser
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 8'h00;
      s2_q <= 8'h00;
      s3_q <= 8'h00;
      level_q <= 8'h00;
    end else begin
      s1_q <= gpio_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      level_q <= (s3_q & agree) | (level_q & ~agree);
    end
  end

  // pin drivers; enable follows direction
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      out_q <= 8'h00;
      oe_q <= 8'h00;
    end else begin
      out_q <= bus.drive & bus.dir;
      oe_q <= bus.dir;
    end
  end
endmodule : dsg_gpio

// ===== hdl/dsg_gpio_if.sv
`timescale 1ns/100ps
interface dsg_gpio_if;
  logic [7:0] dir;
  logic [7:0] drive;
  logic [7:0] sampled;
  modport ctrl (output dir, output drive, input sampled);
  modport pins (input dir, input drive, output sampled);
endinterface : dsg_gpio_if

// ===== hdl/dsg_pkg.sv
// Overview of operation
// - big-endian 33h keeps indirect address bits 8:6 in bits 7:5
// - 34h bits 4:0 hold address bits 5:1; bit 0 always zero
// - both write enables zero means the started access is a read
// - enable bit 1 writes high byte, enable bit 0 writes low byte
// - go bit clears by hardware when the access completes
// - read completion loads the upper fetched byte into data-high
// - read completion loads the lower fetched byte into data-low
// - indirect fields are read/write, reset zero; reserved bits read zero
// - direction register 39h: set bit makes pin an output, reset zero
// - pin with direction bit zero is never driven
// - drive register 3Bh reaches a pin only while its direction is one
// - register 3Dh returns the levels of all eight pins
// - window 60h to 93h shows the 52-byte received control cell
// - header bytes at 00h to 03h, payload 0 to 47 at 04h to 33h
// - big-endian: bit 25 at 30h, 24:17 at 31h, 16:9 at 32h
// - little-endian reverses 30h..33h and swaps data bytes 36h/37h
package dsg_pkg;
  // register offsets
  localparam logic [7:0] OFF_ADDR0 = 8'h30;
  localparam logic [7:0] OFF_ADDR3 = 8'h33;
  localparam logic [7:0] OFF_CTRL = 8'h34;
  localparam logic [7:0] OFF_DATA_A = 8'h36;
  localparam logic [7:0] OFF_DATA_B = 8'h37;
  localparam logic [7:0] OFF_DIR = 8'h39;
  localparam logic [7:0] OFF_DRIVE = 8'h3B;
  localparam logic [7:0] OFF_SAMPLED = 8'h3D;
  localparam logic [7:0] OFF_RX_FIRST = 8'h60;
  localparam logic [7:0] OFF_RX_LAST = 8'h93;
  localparam int RX_BYTES = 52;
  // address slots in logical order
  localparam logic [1:0] SLOT_A25 = 2'h0;
  localparam logic [1:0] SLOT_A24 = 2'h1;
  localparam logic [1:0] SLOT_A16 = 2'h2;
  localparam logic [1:0] SLOT_A8 = 2'h3;
  // field positions
  localparam int POS_A8_LO = 5;
  localparam int POS_WE_LO = 5;
  localparam int POS_GO = 7;
  localparam int POS_WE_HI = 1;
  localparam int POS_WE_LOB = 0;
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam int PIN_COUNT = 8;
  typedef enum {ST_IDLE, ST_BUSY} dsg_state_t;
endpackage : dsg_pkg

// ===== hdl/dsg_top.sv
`timescale 1ns/100ps
module dsg_top (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // microprocessor register port
  input wire logic [7:0] up_addr,
  input wire logic [7:0] up_wdata,
  input wire logic up_wr,
  input wire logic up_rd,
  output logic [7:0] up_rdata,
  output logic up_rvalid,
  // byte-order select, one for big-endian
  input wire logic big_end,
  // internal word memory port
  output logic ext_req,
  output logic [1:0] ext_we,
  output logic [25:1] ext_waddr,
  output logic [15:0] ext_wdata,
  input wire logic [15:0] ext_rdata,
  input wire logic ext_ack,
  // received control cell feed
  input wire logic rx_wr,
  input wire logic [5:0] rx_idx,
  input wire logic [7:0] rx_byte,
  // general-purpose pins
  input wire logic [7:0] gpio_i,
  output logic [7:0] gpio_o,
  output logic [7:0] gpio_oe
);

  ////////////////////////////////////////////////////////////////////////
  // functions

  // logical slot of an address offset under the byte order
  function automatic logic [1:0] slot_of(input logic [7:0] off,
                                         input logic big);
    logic [1:0] rel;
    rel = off[1:0] - dsg_pkg::OFF_ADDR0[1:0];
    slot_of = big ? rel : ~rel;
  endfunction : slot_of

  // true when offset is one of the four address bytes
  function automatic logic is_addr(input logic [7:0] off);
    is_addr = (off >= dsg_pkg::OFF_ADDR0) && (off <= dsg_pkg::OFF_ADDR3);
  endfunction : is_addr

  // true when offset holds the upper data byte
  function automatic logic is_upper(input logic [7:0] off,
                                    input logic big);
    is_upper = big ? (off == dsg_pkg::OFF_DATA_A)
                   : (off == dsg_pkg::OFF_DATA_B);
  endfunction : is_upper

  // true when offset is either data byte
  function automatic logic is_data_off(input logic [7:0] off);
    is_data_off = (off == dsg_pkg::OFF_DATA_A) ||
                  (off == dsg_pkg::OFF_DATA_B);
  endfunction : is_data_off

  ////////////////////////////////////////////////////////////////////////
  // state

  dsg_pkg::dsg_state_t state_q;
  dsg_pkg::dsg_state_t state_d;
  logic a25_q;
  logic [7:0] a24_q;
  logic [7:0] a16_q;
  logic [2:0] a8_q;
  logic [4:0] a5_q;
  logic [1:0] we_q;
  logic go_q;
  logic [7:0] dh_q;
  logic [7:0] dl_q;
  logic [7:0] dir_q;
  logic [7:0] drv_q;
  logic req_q;
  logic [7:0] rdata_q;
  logic rvalid_q;
  logic [7:0] rx_mem [0:dsg_pkg::RX_BYTES-1];

  dsg_gpio_if gpio_bus ();

  ////////////////////////////////////////////////////////////////////////
  // write decode

  // indirect registers only take writes while no access runs
  wire idle = (state_q == dsg_pkg::ST_IDLE);
  wire busy = (state_q == dsg_pkg::ST_BUSY);
  wire [1:0] wslot = slot_of(up_addr, big_end);
  wire wr_ind = up_wr & idle;

  // address bytes by logical slot
  wire wr_addr = wr_ind & is_addr(up_addr);
  wire wr_a25 = wr_addr & (wslot == dsg_pkg::SLOT_A25);
  wire wr_a24 = wr_addr & (wslot == dsg_pkg::SLOT_A24);
  wire wr_a16 = wr_addr & (wslot == dsg_pkg::SLOT_A16);
  wire wr_a8 = wr_addr & (wslot == dsg_pkg::SLOT_A8);

  // control and data bytes
  wire wr_ctrl = wr_ind & (up_addr == dsg_pkg::OFF_CTRL);
  wire wr_data = wr_ind & is_data_off(up_addr);
  wire wr_dh = wr_data & is_upper(up_addr, big_end);
  wire wr_dl = wr_data & ~is_upper(up_addr, big_end);

  // pin registers stay writable during an access
  wire wr_dir = up_wr & (up_addr == dsg_pkg::OFF_DIR);
  wire wr_drv = up_wr & (up_addr == dsg_pkg::OFF_DRIVE);

  // sequencer events
  wire launch = wr_ctrl & up_wdata[dsg_pkg::POS_GO];
  wire finish = busy & ext_ack;
  wire is_read = (we_q == 2'h0);

  // cell bytes beyond the window are dropped
  wire rx_take = rx_wr && (rx_idx < 6'(dsg_pkg::RX_BYTES));

  ////////////////////////////////////////////////////////////////////////
  // read selection

  // indirect register bytes under the byte order
  wire [1:0] rslot = slot_of(up_addr, big_end);
  wire [7:0] addr_byte =
    (rslot == dsg_pkg::SLOT_A25) ? {7'h00, a25_q} :
    (rslot == dsg_pkg::SLOT_A24) ? a24_q :
    (rslot == dsg_pkg::SLOT_A16) ? a16_q :
    {a8_q, 5'h00};
  wire [7:0] ctrl_byte = {go_q, we_q, a5_q};
  wire [7:0] data_byte = is_upper(up_addr, big_end) ? dh_q : dl_q;
  wire is_data = is_data_off(up_addr);

  // received cell window
  wire in_rx = (up_addr >= dsg_pkg::OFF_RX_FIRST) &&
               (up_addr <= dsg_pkg::OFF_RX_LAST);
  wire [7:0] rx_off = up_addr - dsg_pkg::OFF_RX_FIRST;
  wire [7:0] rx_val = rx_mem[rx_off[5:0]];

  // final read mux; unmapped offsets read zero
  wire [7:0] rd_val =
    is_addr(up_addr) ? addr_byte :
    (up_addr == dsg_pkg::OFF_CTRL) ? ctrl_byte :
    is_data ? data_byte :
    (up_addr == dsg_pkg::OFF_DIR) ? dir_q :
    (up_addr == dsg_pkg::OFF_DRIVE) ? drv_q :
    (up_addr == dsg_pkg::OFF_SAMPLED) ? gpio_bus.sampled :
    in_rx ? rx_val :
    dsg_pkg::RST_BYTE;
  wire [7:0] rdata_d = up_rd ? rd_val : rdata_q;

  ////////////////////////////////////////////////////////////////////////
  // outputs

  // register port
  assign up_rdata = rdata_q;
  assign up_rvalid = rvalid_q;

  // memory port; fields hold still while busy
  assign ext_req = req_q;
  assign ext_we = we_q;
  assign ext_waddr = {a25_q, a24_q, a16_q, a8_q, a5_q};
  assign ext_wdata = {dh_q, dl_q};

  // pin side
  assign gpio_bus.dir = dir_q;
  assign gpio_bus.drive = drv_q;

  ////////////////////////////////////////////////////////////////////////
  // indirect access sequencer

  // next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      dsg_pkg::ST_IDLE: begin
        if (launch) begin
          state_d = dsg_pkg::ST_BUSY;
        end
      end
      dsg_pkg::ST_BUSY: begin
        if (ext_ack) begin
          state_d = dsg_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d = dsg_pkg::ST_IDLE;
      end
    endcase
  end

  // state, request and go bit
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= dsg_pkg::ST_IDLE;
      req_q <= 1'b0;
      go_q <= 1'b0;
    end else begin
      state_q <= state_d;
      req_q <= launch | (req_q & ~finish);
      go_q <= launch | (go_q & ~finish);
    end
  end

  // address bytes; writes refused while an access runs
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      a25_q <= 1'b0;
      a24_q <= 8'h00;
      a16_q <= 8'h00;
      a8_q <= 3'h0;
    end else begin
      if (wr_a25) begin
        a25_q <= up_wdata[0];
      end
      if (wr_a24) begin
        a24_q <= up_wdata;
      end
      if (wr_a16) begin
        a16_q <= up_wdata;
      end
      if (wr_a8) begin
        a8_q <= up_wdata[7:dsg_pkg::POS_A8_LO];
      end
    end
  end

  // low address bits and byte enables from the control byte
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      a5_q <= 5'h00;
      we_q <= 2'h0;
    end else if (wr_ctrl) begin
      a5_q <= up_wdata[4:0];
      we_q <= up_wdata[6:dsg_pkg::POS_WE_LO];
    end
  end

  // data bytes; host writes or read completion
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dh_q <= dsg_pkg::RST_BYTE;
      dl_q <= dsg_pkg::RST_BYTE;
    end else begin
      if (finish & is_read) begin
        dh_q <= ext_rdata[15:8];
        dl_q <= ext_rdata[7:0];
      end else begin
        if (wr_dh) begin
          dh_q <= up_wdata;
        end
        if (wr_dl) begin
          dl_q <= up_wdata;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin registers

  // direction and drive bytes
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dir_q <= dsg_pkg::RST_BYTE;
      drv_q <= dsg_pkg::RST_BYTE;
    end else begin
      if (wr_dir) begin
        dir_q <= up_wdata;
      end
      if (wr_drv) begin
        drv_q <= up_wdata;
      end
    end
  end

  dsg_gpio u_gpio (
    .clock(clock),
    .rst_n(rst_n),
    .bus(gpio_bus.pins),
    .gpio_i(gpio_i),
    .gpio_o(gpio_o),
    .gpio_oe(gpio_oe)
  );

  ////////////////////////////////////////////////////////////////////////
  // received cell store; contents undefined until first cell

  always_ff @(posedge clock) begin
    if (rx_take) begin
      rx_mem[rx_idx] <= rx_byte;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read answer, one cycle after the strobe

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= dsg_pkg::RST_BYTE;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= up_rd;
      rdata_q <= rdata_d;
    end
  end

endmodule : dsg_top
